//--- include/omid_consts.svh
// constants for the opcode map and miscellaneous instruction decoder
`ifndef OMID_CONSTS_SVH
`define OMID_CONSTS_SVH

// register offsets on the bus (byte addresses)
`define OMID_OFS_CONV_CTRL 8'h00
`define OMID_OFS_IRQ_CTRL 8'h04
`define OMID_OFS_STATUS 8'h08
`define OMID_OFS_COMP_REF 8'h0c

// reset values
`define OMID_RST_CONV_CTRL 12'h000
`define OMID_RST_IRQ_CTRL 4'h0

// field positions
`define OMID_MODE_BIT 3
`define OMID_IRQ_EN_BIT 2

// first-word opcodes (10 bits)
`define OMID_OP_NOP 10'h000
`define OMID_OP_PD_CLK 10'h002
`define OMID_OP_PD_FLAG_SKIP 10'h003
`define OMID_OP_PD_RAM 10'h008
`define OMID_OP_PD_ARM 10'h05b
`define OMID_OP_BANK_LOW 10'h040
`define OMID_OP_BANK_HIGH 10'h041
`define OMID_OP_WD_RESTART 10'h2a0
`define OMID_OP_WD_DIS_ARM 10'h29c
`define OMID_OP_VD_ENABLE 10'h293
`define OMID_OP_RESULT_RD 10'h279
`define OMID_OP_LOW_RD 10'h249
`define OMID_OP_COMP_LOAD 10'h239
`define OMID_OP_CONV_GO 10'h29f
`define OMID_OP_CONV_SKIP 10'h287
`define OMID_OP_IDX_BRANCH 10'h010
`define OMID_OP_IDX_CALL 10'h030
`define OMID_OP_SKIP_IMM 10'h025
`define OMID_OP_SKIP_PORT 10'h024

// columns and rows
`define OMID_COL_CTRL_RD 6'h24
`define OMID_COL_CTRL_WR 6'h20
`define OMID_ROW_CTRL_ONE 4'h4
`define OMID_ROW_CTRL_THREE 4'h6
`define OMID_COL_TABLE_HI 4'h2
`define OMID_COL_LONG_HI 4'h3

// fixed second-word forms
`define OMID_SW_SKIP_IMM_HI 6'h07
`define OMID_SW_SKIP_PORT 10'h02b

`endif

//--- include/omid_pkg.sv
// types shared by the decoder
package omid_pkg;

   // decoder sequencing, one-hot
   typedef enum logic [2:0] {
      OMID_EXEC = 3'b001,
      OMID_OPER = 3'b010,
      OMID_SKIP = 3'b100
   } omid_state_t;

   // kind of a two-word instruction awaiting its second word
   typedef enum logic [2:0] {
      OMID_K_NONE = 3'h0,
      OMID_K_LONG_BRANCH = 3'h1,
      OMID_K_LONG_CALL = 3'h2,
      OMID_K_IDX_BRANCH = 3'h3,
      OMID_K_IDX_CALL = 3'h4,
      OMID_K_SKIP_IMM = 3'h5,
      OMID_K_SKIP_PORT = 3'h6
   } omid_kind_t;

endpackage

//--- src/omid_decoder.sv
// opcode map and miscellaneous instruction decoder with an ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "omid_consts.svh"

module omid_decoder (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [9:0] INSTR,
   input wire logic INSTR_VALID,
   input wire logic [3:0] ACC_IN,
   input wire logic [3:0] AUX_IN,
   input wire logic [9:0] ADC_RESULT,
   input wire logic ADC_DONE,
   input wire logic WDT_OVF,
   input wire logic PDN_FLAG,
   input wire logic DROP_DETECT_ENABLE_PIN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic PC_INC,
   output logic SKIP_NEXT,
   output logic FETCH_SECOND,
   output logic OPERAND_VALID,
   output omid_pkg::omid_kind_t OPERAND_KIND,
   output logic [8:0] OPERAND,
   output logic FORMAT_ERR,
   output logic CLOCK_OPERATING,
   output logic RAM_BACKUP,
   output logic WATCHDOG_STOPPED,
   output logic TABLE_FETCH,
   output logic [6:0] TABLE_PAGE,
   output logic DROP_DETECT_ARMED,
   output logic ACC_LOAD,
   output logic [3:0] ACC_OUT,
   output logic AUX_LOAD,
   output logic [3:0] AUX_OUT,
   output logic CONV_START,
   output logic CONV_COMPARE,
   output logic [7:0] COMP_REF,
   output logic [3:0] CONV_CTRL_ONE,
   output logic [3:0] CONV_CTRL_TWO,
   output logic [3:0] CONV_CTRL_THREE
);
   import omid_pkg::*;

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   logic pin_meta;
   logic pin_sync;

   // the enable pin is asynchronous; two stages before anything reads it
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= DROP_DETECT_ENABLE_PIN;
         pin_sync <= pin_meta;
      end
   end

   // ----------------------------------------------------------------
   // decoder state
   // ----------------------------------------------------------------
   omid_state_t state, next_state;
   omid_kind_t kind, next_kind;
   logic pd_arm, next_pd_arm;
   logic wd_arm, next_wd_arm;
   logic bank_high, next_bank_high;
   logic wdt_flag, next_wdt_flag;
   logic conv_flag, next_conv_flag;
   logic vd_en, next_vd_en;
   logic [3:0] q1, next_q1;
   logic [3:0] q2, next_q2;
   logic [3:0] q3, next_q3;
   logic [3:0] irq_ctrl, next_irq_ctrl;
   logic [7:0] comp_ref, next_comp_ref;
   logic next_pc_inc, next_skip, next_fetch2, next_oper_valid, next_fmt_err;
   logic [8:0] next_operand;
   logic next_clk_op, next_ram_bk, next_wd_stop;
   logic next_tab_fetch;
   logic [6:0] next_tab_page;
   logic next_acc_load, next_aux_load;
   logic [3:0] next_acc, next_aux;
   logic next_conv_start;

   // ----------------------------------------------------------------
   // bus slave phase capture
   // ----------------------------------------------------------------
   logic wr_pend, next_wr_pend;
   logic [7:0] wr_addr, next_wr_addr;
   logic [31:0] next_rdata;

   logic exec;
   logic [5:0] col;
   logic [3:0] row;
   logic addr_phase;
   logic [31:0] status_word;

   assign exec = (state == OMID_EXEC) && INSTR_VALID;
   assign col = INSTR[9:4];
   assign row = INSTR[3:0];
   assign addr_phase = HSEL && HTRANS[1] && HREADY;
   assign status_word = {22'h000000, pin_sync, vd_en, WATCHDOG_STOPPED, bank_high,
                         pd_arm, wd_arm, PDN_FLAG, wdt_flag, conv_flag, CONV_COMPARE};

   // next values of the decoder, flags and bus-visible registers
   always_comb begin
      next_state = state;
      next_kind = kind;
      next_pd_arm = pd_arm;
      next_wd_arm = wd_arm;
      next_bank_high = bank_high;
      next_vd_en = vd_en;
      next_q1 = q1;
      next_q2 = q2;
      next_q3 = q3;
      next_irq_ctrl = irq_ctrl;
      next_comp_ref = comp_ref;
      next_pc_inc = 1'b0;
      next_skip = 1'b0;
      next_fetch2 = 1'b0;
      next_oper_valid = 1'b0;
      next_fmt_err = 1'b0;
      next_operand = OPERAND;
      next_clk_op = 1'b0;
      next_ram_bk = 1'b0;
      next_wd_stop = WATCHDOG_STOPPED;
      next_tab_fetch = 1'b0;
      next_tab_page = TABLE_PAGE;
      next_acc_load = 1'b0;
      next_aux_load = 1'b0;
      next_acc = ACC_OUT;
      next_aux = AUX_OUT;
      next_conv_start = 1'b0;
      // clears requested by instructions this cycle; hardware sets win below
      next_wdt_flag = wdt_flag;
      next_conv_flag = conv_flag;
      // bus writes land first so that an instruction in the same cycle wins
      if (wr_pend && wr_addr == `OMID_OFS_CONV_CTRL) begin
         next_q1 = HWDATA[3:0];
         next_q2 = HWDATA[7:4];
         next_q3 = HWDATA[11:8];
      end
      if (wr_pend && wr_addr == `OMID_OFS_IRQ_CTRL) begin
         next_irq_ctrl = HWDATA[3:0];
      end
      case (state)
         OMID_EXEC: begin
            if (INSTR_VALID) begin
               next_pc_inc = 1'b1;
               // arms only survive into the very next instruction
               next_pd_arm = (INSTR == `OMID_OP_PD_ARM);
               next_wd_arm = (INSTR == `OMID_OP_WD_DIS_ARM);
               // unassigned codes fall through as a bare step
               case (INSTR)
                  `OMID_OP_PD_CLK: next_clk_op = pd_arm;
                  `OMID_OP_PD_RAM: next_ram_bk = pd_arm;
                  `OMID_OP_PD_FLAG_SKIP: begin
                     // the power-down flag is owned by the core and left as is
                     if (PDN_FLAG) begin
                        next_skip = 1'b1;
                        next_state = OMID_SKIP;
                     end
                  end
                  `OMID_OP_WD_RESTART: begin
                     if (wdt_flag) begin
                        next_skip = 1'b1;
                        next_state = OMID_SKIP;
                        next_wdt_flag = 1'b0;
                     end
                     if (wd_arm) begin
                        next_wd_stop = 1'b1;
                     end
                  end
                  `OMID_OP_BANK_LOW: next_bank_high = 1'b0;
                  `OMID_OP_BANK_HIGH: next_bank_high = 1'b1;
                  `OMID_OP_VD_ENABLE: next_vd_en = 1'b1;
                  `OMID_OP_RESULT_RD: begin
                     next_acc_load = 1'b1;
                     next_aux_load = 1'b1;
                     if (q1[`OMID_MODE_BIT]) begin
                        next_aux = ADC_RESULT[7:4];
                        next_acc = ADC_RESULT[3:0];
                     end else begin
                        next_aux = ADC_RESULT[9:6];
                        next_acc = ADC_RESULT[5:2];
                     end
                  end
                  `OMID_OP_LOW_RD: begin
                     next_acc_load = 1'b1;
                     next_acc = {ADC_RESULT[1:0], 2'b00};
                  end
                  `OMID_OP_COMP_LOAD: begin
                     // only meaningful in comparator mode
                     if (q1[`OMID_MODE_BIT]) begin
                        next_comp_ref = {AUX_IN, ACC_IN};
                     end
                  end
                  `OMID_OP_CONV_GO: begin
                     next_conv_flag = 1'b0;
                     next_conv_start = 1'b1;
                  end
                  `OMID_OP_CONV_SKIP: begin
                     if (!irq_ctrl[`OMID_IRQ_EN_BIT] && conv_flag) begin
                        next_skip = 1'b1;
                        next_state = OMID_SKIP;
                        next_conv_flag = 1'b0;
                     end
                  end
                  `OMID_OP_IDX_BRANCH: next_kind = OMID_K_IDX_BRANCH;
                  `OMID_OP_IDX_CALL: next_kind = OMID_K_IDX_CALL;
                  `OMID_OP_SKIP_IMM: next_kind = OMID_K_SKIP_IMM;
                  `OMID_OP_SKIP_PORT: next_kind = OMID_K_SKIP_PORT;
                  default: begin
                     // column-indexed groups
                     if (col[5:2] == `OMID_COL_TABLE_HI) begin
                        next_tab_fetch = 1'b1;
                        next_tab_page = {bank_high, col[1:0], row};
                     end else if (col[5:2] == `OMID_COL_LONG_HI) begin
                        next_kind = col[1] ? OMID_K_LONG_BRANCH : OMID_K_LONG_CALL;
                     end else if (row >= `OMID_ROW_CTRL_ONE && row <= `OMID_ROW_CTRL_THREE) begin
                        if (col == `OMID_COL_CTRL_RD) begin
                           next_acc_load = 1'b1;
                           next_acc = (row == 4'h4) ? q1 : (row == 4'h5) ? q2 : q3;
                        end else if (col == `OMID_COL_CTRL_WR) begin
                           case (row)
                              4'h4: next_q1 = ACC_IN;
                              4'h5: next_q2 = ACC_IN;
                              default: next_q3 = ACC_IN;
                           endcase
                        end
                     end
                  end
               endcase
               if (next_kind != OMID_K_NONE) begin
                  next_fetch2 = 1'b1;
                  next_state = OMID_OPER;
               end
            end
         end
         OMID_OPER: begin
            // the next word is an operand and never reaches the opcode decode
            if (INSTR_VALID) begin
               next_pc_inc = 1'b1;
               next_oper_valid = 1'b1;
               next_state = OMID_EXEC;
               next_kind = OMID_K_NONE;
               case (kind)
                  OMID_K_LONG_BRANCH, OMID_K_LONG_CALL: begin
                     next_operand = INSTR[8:0];
                     next_fmt_err = !INSTR[9];
                  end
                  OMID_K_IDX_BRANCH, OMID_K_IDX_CALL: begin
                     next_operand = {2'b00, INSTR[8:6], INSTR[3:0]};
                     next_fmt_err = !INSTR[9] || (INSTR[5:4] != 2'b00);
                  end
                  OMID_K_SKIP_IMM: begin
                     next_operand = {5'h00, INSTR[3:0]};
                     next_fmt_err = (INSTR[9:4] != `OMID_SW_SKIP_IMM_HI);
                  end
                  default: begin
                     next_operand = 9'h000;
                     next_fmt_err = (INSTR != `OMID_SW_SKIP_PORT);
                  end
               endcase
            end
         end
         OMID_SKIP: begin
            // the skipped word is consumed and discarded
            if (INSTR_VALID) begin
               next_pc_inc = 1'b1;
               next_state = OMID_EXEC;
               next_pd_arm = 1'b0;
               next_wd_arm = 1'b0;
            end
         end
         default: begin
            next_state = OMID_EXEC;
            next_kind = OMID_K_NONE;
         end
      endcase
      // completion and overflow events win over any clear this cycle
      if (WDT_OVF) begin
         next_wdt_flag = 1'b1;
      end
      if (ADC_DONE) begin
         next_conv_flag = 1'b1;
      end
      // bus: capture the address phase, answer reads one cycle later
      next_wr_pend = addr_phase && HWRITE;
      next_wr_addr = HADDR[7:0];
      next_rdata = HRDATA;
      if (addr_phase && !HWRITE) begin
         case (HADDR[7:0])
            `OMID_OFS_CONV_CTRL: next_rdata = {20'h00000, q3, q2, q1};
            `OMID_OFS_IRQ_CTRL: next_rdata = {28'h0000000, irq_ctrl};
            `OMID_OFS_STATUS: next_rdata = status_word;
            `OMID_OFS_COMP_REF: next_rdata = {24'h000000, comp_ref};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // register every next value
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state <= OMID_EXEC;
         kind <= OMID_K_NONE;
         pd_arm <= 1'b0;
         wd_arm <= 1'b0;
         bank_high <= 1'b0;
         wdt_flag <= 1'b0;
         conv_flag <= 1'b0;
         vd_en <= 1'b0;
         {q3, q2, q1} <= `OMID_RST_CONV_CTRL;
         irq_ctrl <= `OMID_RST_IRQ_CTRL;
         comp_ref <= 8'h00;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         HRDATA <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         PC_INC <= 1'b0;
         SKIP_NEXT <= 1'b0;
         FETCH_SECOND <= 1'b0;
         OPERAND_VALID <= 1'b0;
         OPERAND_KIND <= OMID_K_NONE;
         OPERAND <= 9'h000;
         FORMAT_ERR <= 1'b0;
         CLOCK_OPERATING <= 1'b0;
         RAM_BACKUP <= 1'b0;
         WATCHDOG_STOPPED <= 1'b0;
         TABLE_FETCH <= 1'b0;
         TABLE_PAGE <= 7'h00;
         DROP_DETECT_ARMED <= 1'b0;
         ACC_LOAD <= 1'b0;
         ACC_OUT <= 4'h0;
         AUX_LOAD <= 1'b0;
         AUX_OUT <= 4'h0;
         CONV_START <= 1'b0;
         CONV_COMPARE <= 1'b0;
         COMP_REF <= 8'h00;
         CONV_CTRL_ONE <= 4'h0;
         CONV_CTRL_TWO <= 4'h0;
         CONV_CTRL_THREE <= 4'h0;
      end else begin
         state <= next_state;
         kind <= next_kind;
         pd_arm <= next_pd_arm;
         wd_arm <= next_wd_arm;
         bank_high <= next_bank_high;
         wdt_flag <= next_wdt_flag;
         conv_flag <= next_conv_flag;
         vd_en <= next_vd_en;
         q1 <= next_q1;
         q2 <= next_q2;
         q3 <= next_q3;
         irq_ctrl <= next_irq_ctrl;
         comp_ref <= next_comp_ref;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         HRDATA <= next_rdata;
         HREADYOUT <= 1'b1; // zero wait states, always okay
         HRESP <= 1'b0;
         PC_INC <= next_pc_inc;
         SKIP_NEXT <= next_skip;
         FETCH_SECOND <= next_fetch2;
         OPERAND_VALID <= next_oper_valid;
         OPERAND_KIND <= (state == OMID_OPER) ? kind : OPERAND_KIND;
         OPERAND <= next_operand;
         FORMAT_ERR <= next_fmt_err;
         CLOCK_OPERATING <= next_clk_op;
         RAM_BACKUP <= next_ram_bk;
         WATCHDOG_STOPPED <= next_wd_stop;
         TABLE_FETCH <= next_tab_fetch;
         TABLE_PAGE <= next_tab_page;
         DROP_DETECT_ARMED <= next_vd_en && pin_sync;
         ACC_LOAD <= next_acc_load;
         ACC_OUT <= next_acc;
         AUX_LOAD <= next_aux_load;
         AUX_OUT <= next_aux;
         CONV_START <= next_conv_start;
         CONV_COMPARE <= next_q1[`OMID_MODE_BIT];
         COMP_REF <= next_comp_ref;
         CONV_CTRL_ONE <= next_q1;
         CONV_CTRL_TWO <= next_q2;
         CONV_CTRL_THREE <= next_q3;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence arm_then_clk;
      exec && INSTR == `OMID_OP_PD_ARM ##1 exec && INSTR == `OMID_OP_PD_CLK;
   endsequence
   sequence arm_then_ram;
      exec && INSTR == `OMID_OP_PD_ARM ##1 exec && INSTR == `OMID_OP_PD_RAM;
   endsequence

   nop_only_a: assert property (exec && INSTR == `OMID_OP_NOP |=> PC_INC && !SKIP_NEXT
      && !FETCH_SECOND && !ACC_LOAD && $stable(bank_high) && $stable(q1)) else $error("nop changed state");
   pd_clock_a: assert property (arm_then_clk |=> CLOCK_OPERATING) else $error("armed entry missed");
   pd_ram_a: assert property (arm_then_ram |=> RAM_BACKUP) else $error("armed backup missed");
   unarmed_pd_a: assert property (exec && !pd_arm |=> !CLOCK_OPERATING && !RAM_BACKUP)
      else $error("power-down without arm");
   flag_skip_a: assert property (exec && INSTR == `OMID_OP_PD_FLAG_SKIP |=> SKIP_NEXT == $past(PDN_FLAG))
      else $error("flag skip wrong");
   wd_restart_a: assert property (exec && INSTR == `OMID_OP_WD_RESTART && wdt_flag && !WDT_OVF
      |=> SKIP_NEXT && !wdt_flag) else $error("restart did not skip and clear");
   wd_stop_a: assert property (exec && INSTR == `OMID_OP_WD_DIS_ARM ##1 exec && INSTR == `OMID_OP_WD_RESTART
      |=> WATCHDOG_STOPPED) else $error("watchdog not stopped");
   table_page_a: assert property (exec && col[5:2] == `OMID_COL_TABLE_HI
      |=> TABLE_FETCH && TABLE_PAGE == {$past(bank_high), $past(INSTR[5:0])}) else $error("table page wrong");
   conv_go_a: assert property (exec && INSTR == `OMID_OP_CONV_GO && !ADC_DONE
      |=> CONV_START && !conv_flag ##1 (!CONV_START || ($past(exec) && $past(INSTR) == `OMID_OP_CONV_GO)))
      else $error("start did not clear flag");
   conv_skip_a: assert property (exec && INSTR == `OMID_OP_CONV_SKIP && irq_ctrl[`OMID_IRQ_EN_BIT]
      |=> !SKIP_NEXT) else $error("skip while irq enabled");
   two_word_a: assert property (exec && next_kind != OMID_K_NONE
      |=> FETCH_SECOND && state == OMID_OPER && !ACC_LOAD) else $error("second word not fetched");

endmodule
`default_nettype wire

//--- tb/omid_prog_mem.sv
// program memory model streaming instruction words into the decoder
`timescale 1ns/1ps
`default_nettype none
module omid_prog_mem (
   input wire logic CLK,
   output logic [9:0] INSTR,
   output logic INSTR_VALID
);
   logic [9:0] rom [0:2];

   // idle pattern at time zero
   initial begin
      INSTR = 10'h155;
      INSTR_VALID = 1'b0;
   end

   // one word per edge, back to back; programs hold assigned codes and operand words only
   task automatic play(input int n);
      for (int i = 0; i < n; i++) begin
         INSTR <= rom[i];
         INSTR_VALID <= 1'b1;
         @(posedge CLK);
      end
      // idle bus shows the inverted last word so a stale copy cannot pass
      INSTR <= ~rom[n - 1];
      INSTR_VALID <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "omid_consts.svh"
module tb_top;
   import omid_pkg::*;
   logic CLK = 1'b0, RST_B = 1'b0, ADC_DONE = 1'b0, WDT_OVF = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
   logic PDN_FLAG = 1'b1, DROP_DETECT_ENABLE_PIN = 1'b0, INSTR_VALID, HREADYOUT;
   logic [3:0] ACC_IN = 4'h0, AUX_IN = 4'h0, ACC_OUT, AUX_OUT, CONV_CTRL_ONE, CONV_CTRL_TWO, CONV_CTRL_THREE;
   logic [9:0] ADC_RESULT = 10'h000, INSTR, r;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
   logic [1:0] HTRANS = 2'h0;
   logic [2:0] HSIZE = 3'h2;
   logic [8:0] OPERAND;
   logic [6:0] TABLE_PAGE;
   logic [7:0] COMP_REF;
   logic PC_INC, SKIP_NEXT, FETCH_SECOND, CLOCK_OPERATING, RAM_BACKUP, WATCHDOG_STOPPED, CONV_START;
   logic HRESP, OPERAND_VALID, FORMAT_ERR, DROP_DETECT_ARMED, CONV_COMPARE;
   omid_kind_t OPERAND_KIND;
   int n_mismatch = 0, check_count = 0, seed = 92, n_pc, n_sk, n_fs, n_co, n_rb, n_cs, n_fe, n_ov;

   always #4 CLK = ~CLK;

   omid_decoder dut_u (.CLK, .RST_B, .INSTR, .INSTR_VALID, .ACC_IN, .AUX_IN, .ADC_RESULT, .ADC_DONE, .WDT_OVF,
      .PDN_FLAG, .DROP_DETECT_ENABLE_PIN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT),
      .HRDATA, .HREADYOUT, .HRESP, .PC_INC, .SKIP_NEXT, .FETCH_SECOND, .OPERAND_VALID, .OPERAND_KIND,
      .OPERAND, .FORMAT_ERR, .CLOCK_OPERATING, .RAM_BACKUP, .WATCHDOG_STOPPED, .TABLE_FETCH(), .TABLE_PAGE,
      .DROP_DETECT_ARMED, .ACC_LOAD(), .ACC_OUT, .AUX_LOAD(), .AUX_OUT, .CONV_START, .CONV_COMPARE,
      .COMP_REF, .CONV_CTRL_ONE, .CONV_CTRL_TWO, .CONV_CTRL_THREE);
   omid_prog_mem mem_u (.CLK, .INSTR, .INSTR_VALID);

   // tally pulses at the falling edge: settled there, and no race with the clear in run
   always @(negedge CLK) begin
      n_fe <= n_fe + int'(FORMAT_ERR === 1'b1);
      n_ov <= n_ov + int'(OPERAND_VALID === 1'b1);
      n_pc <= n_pc + int'(PC_INC === 1'b1);
      n_sk <= n_sk + int'(SKIP_NEXT === 1'b1);
      n_fs <= n_fs + int'(FETCH_SECOND === 1'b1);
      n_co <= n_co + int'(CLOCK_OPERATING === 1'b1);
      n_rb <= n_rb + int'(RAM_BACKUP === 1'b1);
      n_cs <= n_cs + int'(CONV_START === 1'b1);
   end

   // expected aux and accumulator pair for a result read in either mode
   function automatic logic [7:0] exp_result(input logic [9:0] res, input logic cmp);
      return cmp ? res[7:0] : res[9:2];
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // two idle edges after the last word let its pulses land and clear
   task automatic run(input int n, input logic [9:0] a, input logic [9:0] b = 10'h0, input logic [9:0] c = 10'h0);
      {n_pc, n_sk, n_fs, n_co, n_rb, n_cs, n_fe, n_ov} = '0;
      mem_u.rom[0] = a;
      mem_u.rom[1] = b;
      mem_u.rom[2] = c;
      mem_u.play(n);
      repeat (2) @(posedge CLK);
      $display("program %h %h %h done", a, b, c);
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= a;
      HWRITE <= wr;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // a hang costs a mismatch and ends the run the normal way
   initial begin
      #100000;
      n_mismatch++;
      finish_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      r = 10'($random(seed));
      run(2, `OMID_OP_NOP, `OMID_OP_NOP);
      chk(n_pc + n_sk + n_fs + n_co + n_rb + n_cs, 2);
      run(1, 10'h0bf);
      chk(TABLE_PAGE, 7'h3f);
      run(2, `OMID_OP_PD_ARM, `OMID_OP_PD_CLK);
      chk(n_co, 1);
      run(1, `OMID_OP_PD_CLK);
      chk(n_co, 0);
      run(3, `OMID_OP_PD_ARM, `OMID_OP_NOP, `OMID_OP_PD_RAM);
      chk(n_rb, 0);
      run(2, `OMID_OP_PD_ARM, `OMID_OP_PD_RAM);
      chk(n_rb, 1);
      run(2, `OMID_OP_PD_FLAG_SKIP, `OMID_OP_NOP);
      chk(n_sk, 1);
      WDT_OVF <= 1'b1;
      @(posedge CLK);
      WDT_OVF <= 1'b0;
      run(2, `OMID_OP_WD_RESTART, `OMID_OP_NOP);
      chk(n_sk, 1);
      run(1, `OMID_OP_WD_RESTART);
      chk(n_sk + int'(WATCHDOG_STOPPED), 0);
      run(2, `OMID_OP_WD_DIS_ARM, `OMID_OP_WD_RESTART);
      chk(WATCHDOG_STOPPED, 1);
      run(2, `OMID_OP_BANK_HIGH, 10'h080 | r[4:0]);
      chk(TABLE_PAGE, 7'h40 + r[4:0]);
      run(2, `OMID_OP_BANK_LOW, 10'h080 | r[5:0]);
      chk(TABLE_PAGE, r[5:0]);
      run(2, 10'h0e5, {1'b1, r[8:0]});
      chk({OPERAND_KIND, OPERAND}, {OMID_K_LONG_BRANCH, r[8:0]});
      run(2, 10'h0e5, `OMID_OP_CONV_GO);
      chk({n_fs[7:0], n_pc[7:0], n_cs[7:0]}, {8'd1, 8'd2, 8'd0});
      run(2, `OMID_OP_SKIP_IMM, {6'h07, r[3:0]});
      chk({n_fe[7:0], OPERAND}, {8'd0, 5'h00, r[3:0]});
      run(2, `OMID_OP_SKIP_PORT, 10'h02a);
      chk({n_ov[7:0], n_fe[7:0], OPERAND_KIND}, {8'd1, 8'd1, OMID_K_SKIP_PORT});
      ADC_DONE <= 1'b1;
      @(posedge CLK);
      ADC_DONE <= 1'b0;
      run(2, `OMID_OP_CONV_SKIP, `OMID_OP_NOP);
      chk(n_sk, 1);
      run(2, `OMID_OP_CONV_SKIP, `OMID_OP_NOP);
      chk(n_sk, 0);
      run(1, `OMID_OP_CONV_GO);
      chk(n_cs, 1);
      ACC_IN <= {1'b0, r[2:0]};
      ADC_RESULT <= r;
      run(2, 10'h204, `OMID_OP_RESULT_RD);
      chk({CONV_CTRL_ONE, AUX_OUT, ACC_OUT}, {1'b0, r[2:0], exp_result(r, 1'b0)});
      run(1, `OMID_OP_LOW_RD);
      chk(ACC_OUT, {r[1:0], 2'b00});
      run(1, 10'h244);
      chk(ACC_OUT, r[2:0]);
      run(1, `OMID_OP_VD_ENABLE);
      chk(DROP_DETECT_ARMED, 1'b0);
      DROP_DETECT_ENABLE_PIN <= 1'b1;
      repeat (4) @(posedge CLK);
      chk(DROP_DETECT_ARMED, 1'b1);
      ahb(1'b1, 32'h0, 32'ha58);
      run(1, `OMID_OP_RESULT_RD);
      chk({CONV_CTRL_TWO, AUX_OUT, ACC_OUT}, {4'h5, exp_result(r, 1'b1)});
      AUX_IN <= r[7:4];
      ACC_IN <= r[3:0];
      run(1, `OMID_OP_COMP_LOAD);
      chk({COMP_REF, CONV_CTRL_THREE, CONV_COMPARE}, {r[7:0], 4'ha, 1'b1});
      ahb(1'b0, 32'h0, 32'h0);
      chk(rd, 32'ha58);
      ahb(1'b0, 32'h40, 32'h0);
      chk(rd, 32'h0);
      chk(HRESP, 1'b0);
      // a set completion flag must not skip while the converter interrupt is enabled
      ahb(1'b1, `OMID_OFS_IRQ_CTRL, 32'h4);
      ADC_DONE <= 1'b1;
      @(posedge CLK);
      ADC_DONE <= 1'b0;
      run(2, `OMID_OP_CONV_SKIP, `OMID_OP_NOP);
      chk(n_sk, 0);
      finish_test();
   end
endmodule
`default_nettype wire
